/* File: verif/ida_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ida_mem_model (
	// clock
	input wire logic clk,
	// memory side
	input wire logic [15:0] memRdAddr,
	output logic [7:0] memRdData,
	input wire ida_pkg::ida_memwr_t memWr
);
	import ida_pkg::*;
	logic [7:0] mem [0:65535];
	// contents derive from the address so reads are checkable without a preload
	initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
	assign memRdData = mem[memRdAddr];
	always @(posedge clk) if (memWr.en) mem[memWr.addr] <= memWr.data;
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ida_pkg::*;
	logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [7:0] paddr = 0, memRdData;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [15:0] memRdAddr, ra;
	ida_req_t coreReq = '0;
	ida_rsp_t coreRsp;
	ida_memwr_t memWr;
	int err_total = 0, compares = 0;
	always #12.5 clk = ~clk;
	ida_core ida_core_i (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.coreReq(coreReq), .coreRsp(coreRsp), .memRdAddr(memRdAddr), .memRdData(memRdData), .memWr(memWr));
	ida_mem_model ida_mem_model_i (.clk(clk), .memRdAddr(memRdAddr), .memRdData(memRdData), .memWr(memWr));
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			err_total++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// one request cycle; the answer is registered, so it is looked at one edge later
	task automatic core(input ida_kind_t k, input logic [7:0] s, input logic [7:0] dd, input logic [7:0] w);
		@(posedge clk);
		coreReq <= '{1'b1, k, s, dd, w};
		#1;
		ra = memRdAddr;
		@(posedge clk);
		coreReq.valid <= 1'b0;
		#1;
	endtask
	task automatic s_reset();
		apb(0, IDA_OFF_ASTAT, 0);
		chk("astat", IDA_ASTAT_RST, rd);
		apb(0, IDA_OFF_PTR1, 0);
		chk("ptr1", 0, rd);
		apb(0, 8'h14, 0);
		chk("unmapped", 1, {rd[30:0], err});
	endtask
	task automatic s_step();
		apb(1, IDA_OFF_BANK, 8'h03);
		apb(1, IDA_OFF_PTR0, 8'hff);
		apb(1, IDA_OFF_PTR1, 8'h10);
		apb(1, IDA_OFF_ASTAT, 8'h01);
		core(IDA_KIND_READ, IDA_VPORT0_ADDR, 8'h20, 0);
		chk("rd addr", 16'h03ff, ra);
		chk("rd rsp", {1'b1, pat(16'h03ff), 1'b0}, coreRsp);
		core(IDA_KIND_WRITE, 8'h20, IDA_VPORT1_ADDR, 8'ha5);
		chk("wr", {1'b1, 16'h0310, 8'ha5}, memWr);
		apb(0, IDA_OFF_PTR0, 0);
		chk("ptr0 wrap", 0, rd);
		apb(0, IDA_OFF_PTR1, 0);
		chk("ptr1 dec", 8'h0f, rd);
		apb(0, IDA_OFF_ASTAT, 0);
		chk("astat kept", 8'h01, rd);
		apb(1, IDA_OFF_ASTAT, 8'h0e);
		core(IDA_KIND_READ, IDA_VPORT1_ADDR, 8'h20, 0);
		apb(0, IDA_OFF_PTR1, 0);
		chk("ptr1 hold", 8'h0f, rd);
	endtask
	task automatic s_zero();
		core(IDA_KIND_READ, IDA_VPORT0_ADDR, 8'h20, 0);
		chk("zero ptr rd", {1'b1, 8'h00, 1'b1}, coreRsp);
		core(IDA_KIND_WRITE, 8'h20, IDA_VPORT0_ADDR, 8'h66);
		chk("zero ptr wr", 0, memWr.en);
		apb(1, IDA_OFF_PTR1, IDA_VPORT1_ADDR);
		core(IDA_KIND_WRITE, 8'h20, IDA_VPORT1_ADDR, 8'h77);
		chk("port wr", 0, memWr.en);
		core(IDA_KIND_READ, IDA_VPORT1_ADDR, 8'h20, 0);
		chk("port rd", {1'b1, 8'h00, 1'b1}, coreRsp);
		apb(0, IDA_OFF_ASTAT, 0);
		chk("flags kept", 8'h0e, rd);
	endtask
	task automatic s_move();
		apb(1, IDA_OFF_ASTAT, 8'h01);
		apb(1, IDA_OFF_PTR0, 8'h40);
		apb(1, IDA_OFF_PTR1, 8'h50);
		core(IDA_KIND_MOVE, IDA_VPORT0_ADDR, 8'h20, 0);
		chk("mv1", {1'b1, 16'h0320, pat(16'h0340)}, memWr);
		apb(1, IDA_OFF_BANK, 8'h05);
		core(IDA_KIND_MOVE, 8'h30, IDA_VPORT1_ADDR, 0);
		chk("mv2", {1'b1, 16'h0550, pat(16'h0530)}, memWr);
		apb(0, IDA_OFF_PTR0, 0);
		chk("mv ptr0", 8'h41, rd);
		apb(0, IDA_OFF_PTR1, 0);
		chk("mv ptr1", 8'h4f, rd);
		core(IDA_KIND_MOVE, IDA_VPORT0_ADDR, IDA_VPORT1_ADDR, 0);
		chk("mv both", {1'b1, 16'h054f, pat(16'h0541)}, memWr);
		apb(0, IDA_OFF_LASTEA, 0);
		chk("last ea", 8'h41, rd);
		apb(0, IDA_OFF_PTR1, 0);
		chk("mv both ptr1", 8'h4e, rd);
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		arst_n <= 1;
		s_reset();
		s_step();
		s_zero();
		s_move();
		end_of_test();
	end
endmodule
`default_nettype wire

/* File: verilog/ida_core.sv */
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ida_core (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core access request and answer
	input wire ida_pkg::ida_req_t coreReq,
	output ida_pkg::ida_rsp_t coreRsp,
	// data memory
	output logic [15:0] memRdAddr,
	input wire logic [7:0] memRdData,
	output ida_pkg::ida_memwr_t memWr
);
	import ida_pkg::*;

	ida_state_t s_q;
	ida_state_t s_d;
	logic setupPh;
	logic accessWr;
	logic mapped;
	logic rdKind;
	logic wrKind;
	logic srcVp0;
	logic srcVp1;
	logic dstVp0;
	logic dstVp1;
	logic srcBad;
	logic dstBad;
	logic [7:0] srcEa;
	logic [7:0] dstEa;
	logic [7:0] readVal;
	logic [7:0] wrVal;
	logic use0;
	logic use1;
	logic [7:0] ptr0Step;
	logic [7:0] ptr1Step;
	logic [1:0] mode0;
	logic [1:0] mode1;

	if (IDA_PTR_W != 8)
	begin : g_chk
		$error("ida_core: pointer width must be 8");
	end

	// the alias decode assumes the two ports sit at distinct addresses
	if (IDA_VPORT0_ADDR == IDA_VPORT1_ADDR)
	begin : g_vp_chk
		$error("ida_core: virtual port addresses must differ");
	end

	assign setupPh = psel && !penable;
	assign accessWr = psel && penable && pwrite;
	assign mapped = paddr == IDA_OFF_PTR0 || paddr == IDA_OFF_PTR1 || paddr == IDA_OFF_BANK
		|| paddr == IDA_OFF_ASTAT || paddr == IDA_OFF_LASTEA;
	// one wait-free access phase; read data was latched during setup
	assign pready = psel && penable;
	assign pslverr = psel && penable && !mapped;
	assign prdata = s_q.prdata;
	assign coreRsp = s_q.rsp;
	assign memWr = s_q.memWr;

	assign rdKind = coreReq.valid && (coreReq.kind == IDA_KIND_READ || coreReq.kind == IDA_KIND_MOVE);
	assign wrKind = coreReq.valid && (coreReq.kind == IDA_KIND_WRITE || coreReq.kind == IDA_KIND_MOVE);
	assign srcVp0 = coreReq.src == IDA_VPORT0_ADDR;
	assign srcVp1 = coreReq.src == IDA_VPORT1_ADDR;
	assign dstVp0 = coreReq.dst == IDA_VPORT0_ADDR;
	assign dstVp1 = coreReq.dst == IDA_VPORT1_ADDR;
	// virtual ports are only address aliases of the pointers
	assign srcEa = srcVp0 ? s_q.ptr0 : (srcVp1 ? s_q.ptr1 : coreReq.src);
	assign dstEa = dstVp0 ? s_q.ptr0 : (dstVp1 ? s_q.ptr1 : coreReq.dst);
	// a pointer aimed at a virtual port or at zero cannot be followed
	assign srcBad = (srcVp0 || srcVp1)
		&& (srcEa == IDA_VPORT0_ADDR || srcEa == IDA_VPORT1_ADDR || srcEa == IDA_ZERO_ADDR);
	assign dstBad = (dstVp0 || dstVp1)
		&& (dstEa == IDA_VPORT0_ADDR || dstEa == IDA_VPORT1_ADDR || dstEa == IDA_ZERO_ADDR);
	assign memRdAddr = {s_q.bank, srcEa};
	assign readVal = srcBad ? 8'h00 : memRdData;
	// a move forwards the value just read in the same cycle
	assign wrVal = coreReq.kind == IDA_KIND_MOVE ? readVal : coreReq.wdata;
	assign mode0 = s_q.astat[IDA_P0MODE_LSB +: 2];
	assign mode1 = s_q.astat[IDA_P1MODE_LSB +: 2];
	// a pointer used on both sides of a move steps once
	assign use0 = (rdKind && srcVp0) || (wrKind && dstVp0);
	assign use1 = (rdKind && srcVp1) || (wrKind && dstVp1);

	// per-pointer stepping; index 0 is pointer 0, index 1 pointer 1
	logic [1:0][7:0] ptrNow;
	logic [1:0][7:0] ptrNew;
	logic [1:0][1:0] modeOf;
	logic [1:0] useOf;
	logic [1:0] busWrOf;
	assign ptrNow = {s_q.ptr1, s_q.ptr0};
	assign modeOf = {mode1, mode0};
	assign useOf = {use1, use0};
	assign busWrOf = {accessWr && paddr == IDA_OFF_PTR1, accessWr && paddr == IDA_OFF_PTR0};
	assign ptr0Step = ptrNew[0];
	assign ptr1Step = ptrNew[1];

	for (genvar i = 0; i < 2; i++)
	begin : g_step
		ida_ptr_step #(
			.WIDTH(IDA_PTR_W)
		) u_step (
			.ptr(ptrNow[i]),
			.mode(modeOf[i]),
			.used(useOf[i]),
			.ptrNext(ptrNew[i])
		);
		// a same-cycle bus write to the pointer wins, so those cycles are left out
		a_step_inc: assert property (@(posedge clk) disable iff (!arst_n)
			useOf[i] && modeOf[i] == IDA_STEP_INC && !busWrOf[i]
			|=> ptrNow[i] == 8'($past(ptrNow[i]) + 8'h01))
			else $error("pointer did not increment after access");
		a_step_dec: assert property (@(posedge clk) disable iff (!arst_n)
			useOf[i] && modeOf[i] == IDA_STEP_DEC && !busWrOf[i]
			|=> ptrNow[i] == 8'($past(ptrNow[i]) - 8'h01))
			else $error("pointer did not decrement after access");
		a_step_hold: assert property (@(posedge clk) disable iff (!arst_n)
			useOf[i] && modeOf[i][1] && !busWrOf[i]
			|=> $stable(ptrNow[i]))
			else $error("pointer moved in hold mode");
		a_step_idle: assert property (@(posedge clk) disable iff (!arst_n)
			!useOf[i] && !busWrOf[i]
			|=> $stable(ptrNow[i]))
			else $error("pointer moved without an access");
		a_step_bus: assert property (@(posedge clk) disable iff (!arst_n)
			busWrOf[i]
			|=> ptrNow[i] == $past(pwdata[7:0]))
			else $error("pointer not loaded from the bus");
		a_step_under: assert property (@(posedge clk) disable iff (!arst_n)
			useOf[i] && modeOf[i] == IDA_STEP_DEC && ptrNow[i] == 8'h00 && !busWrOf[i]
			|=> ptrNow[i] == 8'hff)
			else $error("pointer did not wrap down to all ones");
	end

	always_comb
	begin
		s_d = s_q;
		// stepping lands at the edge that completes the access
		s_d.ptr0 = ptr0Step;
		s_d.ptr1 = ptr1Step;
		// astat is only loaded from the bus, so stepping leaves its flags alone
		s_d.astat = s_q.astat;
		s_d.memWr.en = wrKind && !dstBad;
		s_d.memWr.addr = {s_q.bank, dstEa};
		s_d.memWr.data = wrVal;
		s_d.rsp.valid = rdKind;
		s_d.rsp.data = readVal;
		s_d.rsp.zeroSet = rdKind && srcBad;
		if (rdKind)
			s_d.lastEa = srcEa;
		else if (wrKind)
			s_d.lastEa = dstEa;
		// software writes override a same-cycle step
		if (accessWr)
		begin
			unique case (paddr)
				IDA_OFF_PTR0: s_d.ptr0 = pwdata[7:0];
				IDA_OFF_PTR1: s_d.ptr1 = pwdata[7:0];
				IDA_OFF_BANK: s_d.bank = pwdata[7:0];
				IDA_OFF_ASTAT: s_d.astat = pwdata[7:0];
				default: s_d.astat = s_d.astat;
			endcase
		end
		if (setupPh)
		begin
			unique case (paddr)
				IDA_OFF_PTR0: s_d.prdata = {24'h000000, s_q.ptr0};
				IDA_OFF_PTR1: s_d.prdata = {24'h000000, s_q.ptr1};
				IDA_OFF_BANK: s_d.prdata = {24'h000000, s_q.bank};
				IDA_OFF_ASTAT: s_d.prdata = {24'h000000, s_q.astat};
				IDA_OFF_LASTEA: s_d.prdata = {24'h000000, s_q.lastEa};
				default: s_d.prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q <= '0;
			s_q.ptr0 <= IDA_PTR_RST;
			s_q.ptr1 <= IDA_PTR_RST;
			s_q.bank <= IDA_BANK_RST;
			s_q.astat <= IDA_ASTAT_RST;
		end
		else
			s_q <= s_d;
	end

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	logic busPtrWr;
	assign busPtrWr = accessWr && (paddr == IDA_OFF_PTR0 || paddr == IDA_OFF_PTR1 || paddr == IDA_OFF_ASTAT);

	a_vp_read_zero: assert property (rdKind && srcBad |=> coreRsp.valid && coreRsp.data == 8'h00 && coreRsp.zeroSet)
		else $error("virtual port read did not give zero with zero flag");
	a_vp_write_nop: assert property (coreReq.valid && coreReq.kind == IDA_KIND_WRITE && dstBad |=> !memWr.en)
		else $error("virtual port write reached memory");
	a_zero_ptr_read: assert property (rdKind && (srcVp0 && s_q.ptr0 == 8'h00 || srcVp1 && s_q.ptr1 == 8'h00)
		|=> coreRsp.data == 8'h00 && coreRsp.zeroSet)
		else $error("read through zero pointer not zero");
	a_indirect_addr: assert property (rdKind && srcVp0 |-> memRdAddr == {s_q.bank, s_q.ptr0})
		else $error("indirect read address is not bank and pointer");
	a_banked_write: assert property (wrKind && !dstBad && dstVp1
		|=> memWr.en && memWr.addr == {$past(s_q.bank), $past(s_q.ptr1)})
		else $error("indirect write address wrong");
	a_ptr0_inc: assert property (use0 && mode0 == IDA_STEP_INC && !busPtrWr
		|=> s_q.ptr0 == 8'($past(s_q.ptr0) + 8'h01))
		else $error("pointer 0 did not increment");
	a_ptr1_dec: assert property (use1 && mode1 == IDA_STEP_DEC && !busPtrWr
		|=> s_q.ptr1 == 8'($past(s_q.ptr1) - 8'h01))
		else $error("pointer 1 did not decrement by its field");
	a_ptr_hold: assert property (use0 && mode0[1] && !busPtrWr |=> $stable(s_q.ptr0))
		else $error("pointer 0 moved in hold mode");
	a_ptr_wrap: assert property (use0 && mode0 == IDA_STEP_INC && s_q.ptr0 == 8'hff && !busPtrWr
		|=> s_q.ptr0 == 8'h00)
		else $error("pointer did not wrap to zero");
	a_astat_kept: assert property (coreReq.valid && !accessWr |=> $stable(s_q.astat))
		else $error("arith status changed by a pointer step");
	a_move_single: assert property (coreReq.valid && coreReq.kind == IDA_KIND_MOVE && !dstBad
		|=> memWr.en && memWr.data == $past(readVal) && memWr.addr == {$past(s_q.bank), $past(dstEa)})
		else $error("move did not complete in one cycle");

	// core access path
	a_direct_rd_addr: assert property (rdKind && !srcVp0 && !srcVp1 |-> memRdAddr == {s_q.bank, coreReq.src})
		else $error("direct read address is not bank and operand");
	a_read_data: assert property (rdKind && !srcBad
		|=> coreRsp.valid && coreRsp.data == $past(memRdData) && !coreRsp.zeroSet)
		else $error("read answer does not carry memory data");
	a_idle_no_rsp: assert property (!rdKind |=> !coreRsp.valid)
		else $error("answer without a read");
	a_idle_no_write: assert property (!wrKind |=> !memWr.en)
		else $error("memory write without a request");
	a_direct_write: assert property (wrKind && !dstVp0 && !dstVp1
		|=> memWr.en && memWr.addr == {$past(s_q.bank), $past(coreReq.dst)})
		else $error("direct write address wrong");
	a_write_data: assert property (coreReq.valid && coreReq.kind == IDA_KIND_WRITE && !dstBad
		|=> memWr.data == $past(coreReq.wdata))
		else $error("write data not passed to memory");
	a_zero_ptr_write: assert property (wrKind && (dstVp0 && s_q.ptr0 == 8'h00 || dstVp1 && s_q.ptr1 == 8'h00)
		|=> !memWr.en)
		else $error("write through zero pointer reached memory");
	a_vp_write_flags: assert property (coreReq.valid && coreReq.kind == IDA_KIND_WRITE && dstBad && !accessWr
		|=> $stable(s_q.astat))
		else $error("virtual port write touched the flags");
	a_move_zero_src: assert property (coreReq.valid && coreReq.kind == IDA_KIND_MOVE && srcBad && !dstBad
		|=> memWr.data == 8'h00 && coreRsp.zeroSet)
		else $error("move from a virtual port did not carry zero");
	a_zero_data: assert property (coreRsp.zeroSet |-> coreRsp.data == 8'h00)
		else $error("zero flag with nonzero data");

	// bus registers
	a_bank_load: assert property (accessWr && paddr == IDA_OFF_BANK |=> s_q.bank == $past(pwdata[7:0]))
		else $error("bank select not loaded from the bus");
	a_astat_load: assert property (accessWr && paddr == IDA_OFF_ASTAT |=> s_q.astat == $past(pwdata[7:0]))
		else $error("arith status not loaded from the bus");
	a_rd_astat: assert property (setupPh && paddr == IDA_OFF_ASTAT
		|=> prdata == {24'h000000, $past(s_q.astat)})
		else $error("arith status read back wrong");
	a_rd_ptr0: assert property (setupPh && paddr == IDA_OFF_PTR0
		|=> prdata == {24'h000000, $past(s_q.ptr0)})
		else $error("pointer 0 read back wrong");
	a_rd_bank: assert property (setupPh && paddr == IDA_OFF_BANK
		|=> prdata == {24'h000000, $past(s_q.bank)})
		else $error("bank select read back wrong");
	a_upper_zero: assert property (prdata[31:8] == 24'h000000)
		else $error("read data above the byte not zero");

	c_vp_read: cover property (rdKind && srcBad);
	c_move_vp_both: cover property (coreReq.valid && coreReq.kind == IDA_KIND_MOVE && (srcVp0 || srcVp1)
		&& (dstVp0 || dstVp1));
	c_wrap: cover property (use1 && s_q.ptr1 == 8'h00 && mode1 == IDA_STEP_DEC);
	c_apb_write: cover property (accessWr && paddr == IDA_OFF_ASTAT);
	c_zero_write: cover property (wrKind && dstVp0 && s_q.ptr0 == 8'h00);
endmodule
`default_nettype wire

/* File: verilog/ida_pkg.sv */
`default_nettype none
package ida_pkg;
	// core-side file addresses of the two virtual ports
	localparam logic [7:0] IDA_VPORT0_ADDR = 8'h00;
	localparam logic [7:0] IDA_VPORT1_ADDR = 8'h08;
	localparam logic [7:0] IDA_ZERO_ADDR = 8'h00;
	localparam int IDA_PTR_W = 8;
	localparam int IDA_BANK_W = 8;
	// apb byte offsets
	localparam logic [7:0] IDA_OFF_PTR0 = 8'h00;
	localparam logic [7:0] IDA_OFF_PTR1 = 8'h04;
	localparam logic [7:0] IDA_OFF_BANK = 8'h08;
	localparam logic [7:0] IDA_OFF_ASTAT = 8'h0c;
	localparam logic [7:0] IDA_OFF_LASTEA = 8'h10;
	// arith_status_reg fields
	localparam int IDA_P0MODE_LSB = 0;
	localparam int IDA_P1MODE_LSB = 2;
	localparam logic [7:0] IDA_ASTAT_RST = 8'h0f;
	localparam logic [7:0] IDA_PTR_RST = 8'h00;
	localparam logic [7:0] IDA_BANK_RST = 8'h00;
	// step modes; bit 1 set means no change
	localparam logic [1:0] IDA_STEP_DEC = 2'h0;
	localparam logic [1:0] IDA_STEP_INC = 2'h1;
	localparam logic [1:0] IDA_STEP_HOLD = 2'h2;
	typedef enum logic [1:0]
	{
		IDA_KIND_READ = 2'h0,
		IDA_KIND_WRITE = 2'h1,
		IDA_KIND_MOVE = 2'h2,
		IDA_KIND_NONE = 2'h3
	} ida_kind_t;
	typedef struct packed
	{
		logic valid;
		ida_kind_t kind;
		logic [7:0] src;
		logic [7:0] dst;
		logic [7:0] wdata;
	} ida_req_t;
	typedef struct packed
	{
		logic en;
		logic [15:0] addr;
		logic [7:0] data;
	} ida_memwr_t;
	typedef struct packed
	{
		logic valid;
		logic [7:0] data;
		logic zeroSet;
	} ida_rsp_t;
	typedef struct packed
	{
		logic [7:0] ptr0;
		logic [7:0] ptr1;
		logic [7:0] bank;
		logic [7:0] astat;
		logic [7:0] lastEa;
		logic [31:0] prdata;
		ida_memwr_t memWr;
		ida_rsp_t rsp;
	} ida_state_t;
endpackage
`default_nettype wire

/* File: verilog/ida_ptr_step.sv */
`timescale 1ns/1ps
`default_nettype none
module ida_ptr_step #(
	parameter int WIDTH = 8
) (
	// pointer and control
	input wire logic [WIDTH-1:0] ptr,
	input wire logic [1:0] mode,
	input wire logic used,
	// result
	output logic [WIDTH-1:0] ptrNext
);
	import ida_pkg::*;
	if (WIDTH < 1)
	begin : g_chk
		$error("ida_ptr_step: WIDTH must be at least 1");
	end
	always_comb
	begin
		ptrNext = ptr;
		// wraps naturally at the word width
		if (used && mode == IDA_STEP_DEC)
			ptrNext = ptr - WIDTH'(1);
		else if (used && mode == IDA_STEP_INC)
			ptrNext = ptr + WIDTH'(1);
	end
endmodule
`default_nettype wire
